/* File: verilog/adc_ctrl_map.svh */
// Constants for the serial control front end of the converter
// How it works
// [RL1] One command bit taken per rising shift clock
// [RL2] Host sends control word bit 7 first
// [RL3] Channel codes 0..10 pick analog inputs
// [RL4] Codes 11..13 pick internal test voltages
// [RL5] Channel code steers only the following conversion
// [RL6] Length bits act within their own cycle
// [RL7] Length 00/10 means 12 clocks, 12 bits
// [RL8] Length 11 means 16 bits, four zero pads
// [RL9] 16-bit mode converts after sixteenth falling edge
// [RL10] Length 01 gives upper eight result bits
// [RL11] 8-bit mode converts after eighth falling edge
// [RL12] Host gives exactly the programmed clock count
// [RL13] Length switches at sixth rising shift clock
// [RL14] Format bit picks unsigned or twos complement
// [RL15] Sampling starts at fourth falling edge
// [RL16] Sampling holds to last edge, then done falls
// [RL17] Host keeps command line steady during conversion
// [RL18] Command line ignored after first eight clocks
// [RL19] Order bit picks MSB or LSB first, next cycle
// [RL20] Code 1110 powers down, cycle still completes
// [RL21] Pad zeros last MSB-first, first LSB-first
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define CW_CHAN_MSB 7
`define CW_CHAN_LSB 4
`define CW_LEN_HI 3
`define CW_LEN_LO 2
`define CW_ORDER_BIT 1
`define CW_SIGNED_BIT 0
`define CW_RESET 8'h00
`define CW_BITS 5'h08

// ----------------------------------------
// Codes and counts
// ----------------------------------------
`define CHAN_LAST_INPUT 4'hA
`define CHAN_POWER_DOWN 4'hE
`define LEN_CHANGE_RISE 5'h06
`define SAMPLE_START_FALL 5'h04
`define IO_LEN_8 5'h08
`define IO_LEN_12 5'h0C
`define IO_LEN_16 5'h10

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 8
`define DONE_DELAY_NS 100

`endif

/* File: verilog/adc_ctrl_pkg.sv */
// Types for the serial control front end
package adc_ctrl_pkg;

    typedef struct packed {
        logic [3:0] chan;
        logic length_sel_hi;
        logic length_sel_lo;
        logic reverse_order_sel;
        logic signed_format_sel;
    } control_word_t;

    typedef struct packed {
        logic chip_sel_n;
        logic shift_clock;
        logic serial_cmd_in;
    } link_pins_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_IO = 4'b0010,
        ST_DELAY = 4'b0100,
        ST_CONVERT = 4'b1000
    } io_state_t;

endpackage

/* File: verilog/pin_sync.sv */
// Two-stage synchroniser for the link pins
`timescale 1ns/10ps
module pin_sync (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire adc_ctrl_pkg::link_pins_t pins_i,
    output adc_ctrl_pkg::link_pins_t pins_o
);
    import adc_ctrl_pkg::*;

    link_pins_t stage1;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage1 <= 3'b100;
            pins_o <= 3'b100;
        end else begin
            stage1 <= pins_i;
            pins_o <= stage1;
        end
    end
endmodule

/* File: verilog/result_format.sv */
// Builds the output word from a raw result, left-justified except in 16-bit LSB-first mode, where it is right-justified
`timescale 1ns/10ps
module result_format (
    input wire logic [11:0] result_i,
    input wire logic signed_format_sel_i,
    input wire logic reverse_order_sel_i,
    input wire logic [4:0] io_len_i,
    output logic [15:0] word_o
);
    `include "adc_ctrl_map.svh"

    wire [11:0] coded;
    wire [11:0] reversed;
    wire [15:0] msb_word;
    wire [15:0] lsb_word;

    // ----------------------------------------
    // Sign and order
    // ----------------------------------------
    assign coded = {result_i[11] ^ signed_format_sel_i, result_i[10:0]}; // [RL14]

    genvar i;
    generate
        for (i = 0; i < 12; i = i + 1) begin : g_rev
            assign reversed[i] = coded[11 - i];
        end
    endgenerate

    assign msb_word = {coded, 4'h0}; // [RL8] [RL10] [RL21]
    assign lsb_word = (io_len_i == `IO_LEN_16) ? {4'h0, reversed} : // [RL21]
                      (io_len_i == `IO_LEN_8) ? {reversed[7:0], 8'h00} : // [RL10]
                      {reversed, 4'h0};
    assign word_o = reverse_order_sel_i ? lsb_word : msb_word; // [RL19]
endmodule

/* File: verilog/adc_serial_control.sv */
// I/O cycle framing, control word capture and conversion start
`timescale 1ns/10ps
module adc_serial_control (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic chip_sel_n_i,
    input wire logic shift_clock_i,
    input wire logic serial_cmd_in_i,
    input wire logic conv_done_i,
    input wire logic [11:0] conv_result_i,
    output logic serial_data_o,
    output logic serial_data_oe_o,
    output logic conversion_done_o,
    output logic conv_start_o,
    output logic sample_en_o,
    output logic [3:0] channel_sel_o,
    output logic test_voltage_sel_o,
    output logic power_down_o,
    output adc_ctrl_pkg::control_word_t control_word_o
);
    import adc_ctrl_pkg::*;
    `include "adc_ctrl_map.svh"

    localparam int DELAY_CYC_RAW = (`DONE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int DELAY_CYC = (DELAY_CYC_RAW < 1) ? 1 : DELAY_CYC_RAW;
    localparam logic [7:0] DELAY_LAST = 8'(DELAY_CYC - 1);

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic [4:0] io_length(input logic hi, input logic lo);
        if (hi && lo) begin
            io_length = `IO_LEN_16;
        end else if (!hi && lo) begin
            io_length = `IO_LEN_8;
        end else begin
            io_length = `IO_LEN_12;
        end
    endfunction

    function automatic logic is_power_down(input logic [3:0] code);
        is_power_down = (code == `CHAN_POWER_DOWN); // [RL20]
    endfunction

    function automatic logic is_test_code(input logic [3:0] code);
        is_test_code = (code > `CHAN_LAST_INPUT) && (code < `CHAN_POWER_DOWN); // [RL4]
    endfunction

    // ----------------------------------------
    // Pin sampling
    // ----------------------------------------
    link_pins_t pins_raw;
    link_pins_t pins;
    assign pins_raw = '{chip_sel_n: chip_sel_n_i, shift_clock: shift_clock_i, serial_cmd_in: serial_cmd_in_i};

    pin_sync u_sync (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .pins_i(pins_raw),
        .pins_o(pins)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    io_state_t state;
    logic sclk_q;
    logic cs_n_q;
    logic [4:0] rise_cnt;
    logic [4:0] fall_cnt;
    logic [7:0] control_word_register;
    logic [1:0] len_cur;
    logic [15:0] out_shift;
    logic [15:0] saved_word;
    logic [7:0] delay_cnt;
    logic pd_cycle;

    // ----------------------------------------
    // Edge and event decode
    // ----------------------------------------
    wire sclk_rise;
    wire sclk_fall;
    wire cs_fall;
    wire active;
    wire take_bit;
    wire len_update;
    wire [4:0] cur_len;
    wire sample_start;
    wire io_end;
    wire [3:0] chan_now;
    wire pd_now;
    wire [15:0] formatted;
    wire [15:0] next_shift;
    wire [7:0] next_cmd;
    control_word_t ctrl;
    wire delay_last;
    wire conv_finish;
    wire io_end_run;
    wire io_end_pd;
    wire test_now;
    wire [4:0] out_len;

    assign active = ~pins.chip_sel_n;
    assign sclk_rise = active & pins.shift_clock & ~sclk_q;
    assign sclk_fall = active & ~pins.shift_clock & sclk_q;
    assign cs_fall = cs_n_q & ~pins.chip_sel_n;
    assign take_bit = (state == ST_IO) && sclk_rise && (rise_cnt < `CW_BITS); // [RL1] [RL18]
    assign next_cmd = {control_word_register[6:0], pins.serial_cmd_in}; // [RL2]
    assign len_update = take_bit && (rise_cnt == `LEN_CHANGE_RISE - 5'h01); // [RL6] [RL13]
    assign cur_len = io_length(len_cur[1], len_cur[0]); // [RL7] [RL9] [RL11]
    assign sample_start = (state == ST_IO) && sclk_fall && (fall_cnt == `SAMPLE_START_FALL - 5'h01); // [RL15]
    assign io_end = (state == ST_IO) && sclk_fall && (fall_cnt == cur_len - 5'h01); // [RL7] [RL9] [RL11]
    assign chan_now = control_word_register[3:0];
    assign pd_now = is_power_down(chan_now); // [RL20]
    assign test_now = is_test_code(chan_now); // [RL4]
    assign next_shift = {out_shift[14:0], 1'b0};
    assign ctrl = control_word_register;
    assign delay_last = (state == ST_DELAY) && (delay_cnt == DELAY_LAST); // [RL16]
    assign conv_finish = (state == ST_CONVERT) && conv_done_i;
    assign io_end_run = io_end && !pd_cycle; // [RL16]
    assign io_end_pd = io_end && pd_cycle; // [RL20]
    assign out_len = io_length(control_word_o.length_sel_hi, control_word_o.length_sel_lo);

    result_format u_fmt (
        .result_i(conv_result_i),
        .signed_format_sel_i(control_word_o.signed_format_sel),
        .reverse_order_sel_i(control_word_o.reverse_order_sel),
        .io_len_i(out_len),
        .word_o(formatted)
    );

    // ----------------------------------------
    // Edge history
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sclk_q <= pins.shift_clock;
            cs_n_q <= pins.chip_sel_n;
        end
    end

    // ----------------------------------------
    // Done delay count
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            delay_cnt <= 8'h00;
        end else if (io_end) begin
            delay_cnt <= 8'h00;
        end else if ((state == ST_DELAY) && !delay_last) begin
            delay_cnt <= delay_cnt + 8'h01; // [RL16]
        end
    end

    // ----------------------------------------
    // Power down of the running cycle
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pd_cycle <= 1'b0;
        end else if (cs_fall) begin
            pd_cycle <= 1'b0;
        end else if (sample_start) begin
            pd_cycle <= pd_now; // [RL20]
        end
    end

    // ----------------------------------------
    // Cycle framing
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            rise_cnt <= 5'h00;
            fall_cnt <= 5'h00;
        end else if (!active) begin
            state <= ST_IDLE;
            rise_cnt <= 5'h00;
            fall_cnt <= 5'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cs_fall) begin
                        state <= ST_IO;
                    end
                end
                ST_IO: begin
                    if (sclk_rise && rise_cnt != 5'h1F) begin
                        rise_cnt <= rise_cnt + 5'h01;
                    end
                    if (io_end) begin
                        rise_cnt <= 5'h00;
                        fall_cnt <= 5'h00;
                        state <= pd_cycle ? ST_IO : ST_DELAY; // [RL20]
                    end else if (sclk_fall) begin
                        fall_cnt <= fall_cnt + 5'h01;
                    end
                end
                ST_DELAY: begin
                    if (delay_last) begin
                        state <= ST_CONVERT; // [RL16]
                    end
                end
                ST_CONVERT: begin
                    if (conv_finish) begin
                        state <= ST_IO;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Control word capture
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            control_word_register <= `CW_RESET;
            len_cur <= 2'b00;
            control_word_o <= `CW_RESET;
        end else begin
            if (cs_fall) begin
                control_word_register <= `CW_RESET;
            end else if (take_bit) begin
                control_word_register <= next_cmd; // [RL1]
            end
            if (len_update) begin
                len_cur <= next_cmd[1:0]; // [RL6] [RL13]
            end
            if (io_end) begin
                control_word_o <= ctrl; // [RL5] [RL19]
            end
        end
    end

    // ----------------------------------------
    // Sampling, power down and conversion start
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sample_en_o <= 1'b0;
            channel_sel_o <= 4'h0;
            test_voltage_sel_o <= 1'b0;
            power_down_o <= 1'b1;
            conv_start_o <= 1'b0;
            conversion_done_o <= 1'b1;
        end else begin
            conv_start_o <= 1'b0;
            if (!active) begin
                sample_en_o <= 1'b0;
                conversion_done_o <= 1'b1;
            end else if (sample_start) begin
                channel_sel_o <= chan_now; // [RL3] [RL5]
                test_voltage_sel_o <= test_now; // [RL4]
                power_down_o <= pd_now; // [RL20]
                sample_en_o <= !pd_now; // [RL15]
            end else if (io_end) begin
                sample_en_o <= 1'b0; // [RL16]
            end else if (delay_last) begin
                conversion_done_o <= 1'b0; // [RL16]
                conv_start_o <= 1'b1; // [RL7] [RL9] [RL11]
            end else if (conv_finish) begin
                conversion_done_o <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Result output
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_shift <= 16'h0000;
            saved_word <= 16'h0000;
            serial_data_o <= 1'b0;
            serial_data_oe_o <= 1'b0;
        end else if (!active) begin
            serial_data_oe_o <= 1'b0;
        end else if (cs_fall) begin
            serial_data_oe_o <= 1'b1;
            out_shift <= saved_word;
            serial_data_o <= saved_word[15];
        end else if (conv_finish) begin
            saved_word <= formatted; // [RL8] [RL10] [RL14] [RL21]
            out_shift <= formatted;
            serial_data_o <= formatted[15];
        end else if (io_end_run) begin
            serial_data_o <= 1'b0;
        end else if (io_end_pd) begin
            out_shift <= saved_word;
            serial_data_o <= saved_word[15];
        end else if (state == ST_IO && sclk_fall) begin
            out_shift <= next_shift;
            serial_data_o <= next_shift[15];
        end
    end
endmodule

/* File: test/adc_serial_control_monitor.sv */
// Port assertions for the serial control front end
`timescale 1ns/10ps
module adc_serial_control_monitor (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic chip_sel_n_i,
    input wire logic conv_done_i,
    input wire logic serial_data_o,
    input wire logic serial_data_oe_o,
    input wire logic conversion_done_o,
    input wire logic conv_start_o,
    input wire logic sample_en_o,
    input wire logic [3:0] channel_sel_o,
    input wire logic test_voltage_sel_o,
    input wire logic power_down_o,
    input wire adc_ctrl_pkg::control_word_t control_word_o
);
    import adc_ctrl_pkg::*;
    default clocking dc @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_start_one_cycle: assert property (conv_start_o |=> !conv_start_o)
        else $error("start pulse too long");
    a_start_done_low: assert property (conv_start_o |-> ##[0:1] !conversion_done_o)
        else $error("done not low at start");
    a_done_rises: assert property (conv_done_i && !conversion_done_o |=> conversion_done_o)
        else $error("done not high after engine");
    a_pd_no_start: assert property (power_down_o |-> !conv_start_o)
        else $error("conversion in power down");
    a_no_sample_conv: assert property (!conversion_done_o |-> !sample_en_o)
        else $error("sampling during conversion");
    a_data_zero_conv: assert property (!conversion_done_o && serial_data_oe_o |-> !serial_data_o)
        else $error("data not zero during conversion");
    a_test_code: assert property (test_voltage_sel_o |-> channel_sel_o inside {4'hB, 4'hC, 4'hD})
        else $error("test voltage with wrong code");
    a_cw_idle: assert property (chip_sel_n_i [*6] |-> $stable(control_word_o))
        else $error("control word moved while deselected");
    c_conversion: cover property (conv_start_o);
    c_power_down: cover property (power_down_o && !chip_sel_n_i);
    c_test_voltage: cover property (test_voltage_sel_o && sample_en_o);
endmodule
bind adc_serial_control adc_serial_control_monitor mon (.core_clk_i, .rst_n_i, .chip_sel_n_i, .conv_done_i,
    .serial_data_o, .serial_data_oe_o, .conversion_done_o, .conv_start_o, .sample_en_o, .channel_sel_o,
    .test_voltage_sel_o, .power_down_o, .control_word_o);

/* File: test/host_link_model.sv */
// Host side model driving the serial control link
`timescale 1ns/10ps
module host_link_model (
    input wire logic core_clk_i,
    input wire logic serial_data_i,
    output logic chip_sel_n_o,
    output logic shift_clock_o,
    output logic serial_cmd_o
);
    initial begin
        chip_sel_n_o = 1'b1;
        shift_clock_o = 1'b0;
        serial_cmd_o = 1'b0;
    end
    // One frame, word sent first, output bits captured
    task automatic frame(input logic [7:0] word, input int n, output logic [15:0] seen);
        seen = 16'h0000;
        @(posedge core_clk_i);
        chip_sel_n_o <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        for (int i = 0; i < n; i++) begin
            serial_cmd_o <= (i < 8) ? word[7 - i] : ((word[7:4] == 4'hE) ? i[0] : word[0]);
            repeat (5) @(posedge core_clk_i);
            shift_clock_o <= 1'b1;
            repeat (2) @(posedge core_clk_i);
            seen[i] = serial_data_i;
            repeat (3) @(posedge core_clk_i);
            shift_clock_o <= 1'b0;
        end
    endtask
    task automatic release_cs();
        @(posedge core_clk_i);
        chip_sel_n_o <= 1'b1;
        repeat (8) @(posedge core_clk_i);
    endtask
endmodule

/* File: test/tb.sv */
// Self-checking bench for the serial control front end
`timescale 1ns/10ps
`define CHECK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb;
    import adc_ctrl_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic conv_done = 1'b0;
    logic [11:0] conv_result = 12'h000;
    logic [1:0] eng_cnt = 2'h0;
    logic cs_n, sclk, cmd, data, data_oe, data_line, done, start, sample_en, test_sel, pd;
    logic [3:0] chan_sel;
    control_word_t cw;
    int checks = 0;
    int miscompares = 0;
    always #4 core_clk = ~core_clk;
    assign data_line = data_oe ? data : ~data;
    host_link_model host (.core_clk_i(core_clk), .serial_data_i(data_line), .chip_sel_n_o(cs_n),
        .shift_clock_o(sclk), .serial_cmd_o(cmd));
    adc_serial_control dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .chip_sel_n_i(cs_n), .shift_clock_i(sclk),
        .serial_cmd_in_i(cmd), .conv_done_i(conv_done), .conv_result_i(conv_result), .serial_data_o(data),
        .serial_data_oe_o(data_oe), .conversion_done_o(done), .conv_start_o(start), .sample_en_o(sample_en),
        .channel_sel_o(chan_sel), .test_voltage_sel_o(test_sel), .power_down_o(pd), .control_word_o(cw));
    // Conversion engine answers three cycles after start
    always @(posedge core_clk) begin
        eng_cnt <= start ? 2'h3 : ((eng_cnt != 2'h0) ? eng_cnt - 2'h1 : 2'h0);
        conv_done <= (eng_cnt == 2'h1);
    end
    function automatic int io_len(input logic [7:0] w);
        return (w[3:2] == 2'b01) ? 8 : ((w[3:2] == 2'b11) ? 16 : 12);
    endfunction
    function automatic logic [15:0] expect_bits(input logic [7:0] w, input logic [11:0] r);
        logic [15:0] full;
        logic [15:0] bits;
        int n;
        n = io_len(w);
        full = {(w[0] ? {~r[11], r[10:0]} : r), 4'h0};
        bits = 16'h0000;
        for (int i = 0; i < n; i++) bits[i] = w[1] ? full[16 - n + i] : full[15 - i];
        return bits;
    endfunction
    task automatic test_done();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wait_done(input logic lvl, output int k);
        k = 0;
        while (done !== lvl && k < 200) begin
            @(negedge core_clk);
            k++;
        end
        if (k >= 200) begin
            miscompares++;
            test_done();
        end
    endtask
    initial begin
        logic [7:0] words [10];
        logic [7:0] wd;
        logic [7:0] last_w;
        logic [11:0] last_r;
        logic [15:0] seen;
        logic pdn;
        int k;
        words = '{8'h30, 8'hB9, 8'hA2, 8'hCF, 8'hDC, 8'h07, 8'h14, 8'hE4, 8'hE8, 8'h54};
        last_w = 8'h00;
        last_r = 12'h000;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        `CHECK("pd", 1'b1, pd)
        `CHECK("cw", 8'h00, cw)
        for (int f = 0; f < 10; f++) begin
            wd = words[f];
            pdn = (wd[7:4] == 4'hE);
            @(posedge core_clk);
            conv_result <= 12'h8C3 + 12'h135 * 12'(f);
            host.frame(wd, io_len(wd), seen);
            `CHECK("sample", !pdn, sample_en)
            if (f > 0 && io_len(last_w) == io_len(wd)) `CHECK("out", expect_bits(last_w, last_r), seen)
            if (pdn) begin
                repeat (20) @(negedge core_clk);
                `CHECK("done", 1'b1, done)
            end else begin
                wait_done(1'b0, k);
                `CHECK("sample", 1'b0, sample_en)
                `CHECK("delay", 1'b1, (k >= 14 && k <= 20))
                wait_done(1'b1, k);
                last_w = wd;
                last_r = conv_result;
            end
            `CHECK("pd", pdn, pd)
            `CHECK("test", (wd[7:4] inside {4'hB, 4'hC, 4'hD}), test_sel)
            if (!pdn) `CHECK("chan", wd[7:4], chan_sel)
            `CHECK("cw", wd, cw)
            host.release_cs();
        end
        `CHECK("oe", 1'b0, data_oe)
        test_done();
    end
endmodule
